// >>> spl_regs.svh
`ifndef SPL_REGS_SVH
`define SPL_REGS_SVH

// =============================================================
// Opcodes
`define SPL_OP_PREFIX1 8'h3d
`define SPL_OP_PREFIX2 8'h2a
`define SPL_OP_PREFIX3 8'h7f
`define SPL_OP_PROG_PMAP 8'hfc
`define SPL_OP_LOCKDOWN 8'h30
`define SPL_OP_READ_PMAP 8'h32
`define SPL_OP_READ_LMAP 8'h35

// =============================================================
// Frame lengths in bytes
`define SPL_PMAP_BYTES 4
`define SPL_LMAP_BYTES 8
`define SPL_DUMMY_BYTES 3
`define SPL_ADDR_BYTES 3

// =============================================================
// Map values and sector 0 field positions
`define SPL_PMAP_ERASED 8'hff
`define SPL_LMAP_CLEAR 8'h00
`define SPL_LOCK_FULL 8'hff
`define SPL_LOCK_0A 8'hc0
`define SPL_LOCK_0B 8'h30
`define SPL_S0A_BIT 7
`define SPL_S0B_BIT 5
`define SPL_SUB0A_LIMIT 18'h00800
`define SPL_SECTOR_LSB 15
`define SPL_UNDEF_BYTE 8'h00

// =============================================================
// Timing
`define SPL_CLK_MHZ 100
`define SPL_PROGRAM_CYCLE_TIME_US 4000
`define SPL_PROGRAM_CYCLES (`SPL_PROGRAM_CYCLE_TIME_US * `SPL_CLK_MHZ)

`endif

// >>> spl_pkg.sv
package spl_pkg;
    // Command decoder states
    typedef enum logic [3:0] {
        SPL_ST_OPCODE,
        SPL_ST_PRE2,
        SPL_ST_PRE3,
        SPL_ST_PRE4,
        SPL_ST_PMAP_DATA,
        SPL_ST_LOCK_ADDR,
        SPL_ST_DUMMY,
        SPL_ST_READ_OUT,
        SPL_ST_IGNORE
    } spl_state_t;

    // Which map a read frame returns
    typedef enum logic {
        SPL_SRC_PMAP,
        SPL_SRC_LMAP
    } spl_src_t;

    typedef logic [7:0] spl_byte_t;
    typedef logic [17:0] spl_addr_t;
endpackage

// >>> spl_prog_timer.sv
`timescale 1ns/1ps
// =============================================================
// Self-timed cycle counter
module spl_prog_timer #(
    parameter int CYCLES = 400000
) (
    input wire logic ref_clk, // System clock
    input wire logic resetn, // Async reset, active low
    input wire logic start, // One-cycle start pulse
    output logic busy // High while the cycle runs
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q; // Cycles remaining

    // Count down; a start while busy is ignored by the caller
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= CW'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);
endmodule

// >>> spl_lockdown_cmds.sv
`timescale 1ns/1ps
`include "spl_regs.svh"
module spl_lockdown_cmds #(
    parameter int PROGRAM_CYCLES = `SPL_PROGRAM_CYCLES
) (
    input wire logic ref_clk, // System clock, 100 MHz
    input wire logic resetn, // Async reset, active low
    input wire logic cs_n_i, // Chip select pin, active low
    input wire logic sck_i, // Serial clock pin
    input wire logic si_i, // Serial data in pin
    output logic so_o, // Serial data out
    output logic so_oe, // Serial out enable, high drives
    input wire logic prot_en_i, // Global sector protection enable
    input wire logic chk_valid_i, // Program/erase check request
    input wire spl_pkg::spl_addr_t chk_addr_i, // Address to check
    output logic chk_done_o, // Check answer strobe
    output logic chk_refuse_o, // Operation must be refused
    output logic chk_locked_o, // Target is locked down
    output logic busy_o, // Self-timed cycle running
    output logic buf_clobber_o, // SRAM buffer overwritten pulse
    output logic [31:0] pmap_o, // Protection map, byte 0 low
    output logic [63:0] lmap_o // Lockdown map, byte 0 low
);
    import spl_pkg::*;

    // =========================================================
    // Pin synchronisers
    logic [1:0] cs_sync_q, sck_sync_q, si_sync_q; // Two-flop chains
    logic cs_last_q, sck_last_q; // Edge detect history
    logic cs_act, sck_rise, sck_fall, cs_rise, si_s;

    // Pins come from the host's domain; two flops before use
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cs_sync_q <= 2'h3;
            sck_sync_q <= 2'h0;
            si_sync_q <= 2'h0;
            cs_last_q <= 1'b1;
            sck_last_q <= 1'b0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], cs_n_i};
            sck_sync_q <= {sck_sync_q[0], sck_i};
            si_sync_q <= {si_sync_q[0], si_i};
            cs_last_q <= cs_sync_q[1];
            sck_last_q <= sck_sync_q[1];
        end
    end

    assign cs_act = ~cs_sync_q[1];
    assign si_s = si_sync_q[1];
    assign cs_rise = cs_sync_q[1] & ~cs_last_q;
    // Edges only count inside a frame; SCK idles either level
    assign sck_rise = cs_act & sck_sync_q[1] & ~sck_last_q;
    assign sck_fall = cs_act & ~sck_sync_q[1] & sck_last_q;

    // =========================================================
    // Byte assembly on SCK rising edges
    logic [2:0] bit_cnt_q; // Bits of the current byte
    logic [6:0] shift_q; // Partial byte, MSB first
    logic byte_done;
    spl_byte_t byte_v;

    assign byte_done = sck_rise & (bit_cnt_q == 3'h7);
    assign byte_v = {shift_q, si_s};

    // Bit counter restarts with every frame
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 7'h00;
        end else if (!cs_act) begin
            bit_cnt_q <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q <= {shift_q[5:0], si_s};
        end
    end

    // =========================================================
    // Command decoder
    spl_state_t state_q; // Current frame phase
    spl_src_t src_q; // Map chosen for read frames
    logic [1:0] cnt_q; // Dummy/address/map byte pointer
    logic busy;

    // Opcode bytes are matched one at a time; a miss idles out
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= SPL_ST_OPCODE;
            src_q <= SPL_SRC_PMAP;
            cnt_q <= 2'h0;
        end else if (!cs_act) begin
            state_q <= SPL_ST_OPCODE;
            cnt_q <= 2'h0;
        end else if (byte_done) begin
            case (state_q)
                SPL_ST_OPCODE: begin
                    if (busy) begin
                        // No new command while a cycle runs
                        state_q <= SPL_ST_IGNORE;
                    end else if (byte_v == `SPL_OP_PREFIX1) begin
                        state_q <= SPL_ST_PRE2;
                    end else if (byte_v == `SPL_OP_READ_PMAP) begin
                        state_q <= SPL_ST_DUMMY;
                        src_q <= SPL_SRC_PMAP;
                    end else if (byte_v == `SPL_OP_READ_LMAP) begin
                        state_q <= SPL_ST_DUMMY;
                        src_q <= SPL_SRC_LMAP;
                    end else begin
                        state_q <= SPL_ST_IGNORE;
                    end
                end
                SPL_ST_PRE2: begin
                    state_q <= (byte_v == `SPL_OP_PREFIX2) ?
                        SPL_ST_PRE3 : SPL_ST_IGNORE;
                end
                SPL_ST_PRE3: begin
                    state_q <= (byte_v == `SPL_OP_PREFIX3) ?
                        SPL_ST_PRE4 : SPL_ST_IGNORE;
                end
                SPL_ST_PRE4: begin
                    cnt_q <= 2'h0;
                    if (byte_v == `SPL_OP_PROG_PMAP) begin
                        state_q <= SPL_ST_PMAP_DATA;
                    end else if (byte_v == `SPL_OP_LOCKDOWN) begin
                        state_q <= SPL_ST_LOCK_ADDR;
                    end else begin
                        state_q <= SPL_ST_IGNORE;
                    end
                end
                SPL_ST_PMAP_DATA: begin
                    // Two-bit pointer wraps after byte 3
                    cnt_q <= cnt_q + 2'h1;
                end
                SPL_ST_LOCK_ADDR: begin
                    if (cnt_q != 2'(`SPL_ADDR_BYTES)) begin
                        cnt_q <= cnt_q + 2'h1;
                    end
                end
                SPL_ST_DUMMY: begin
                    if (cnt_q == 2'(`SPL_DUMMY_BYTES - 1)) begin
                        state_q <= SPL_ST_READ_OUT;
                    end else begin
                        cnt_q <= cnt_q + 2'h1;
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // =========================================================
    // Program map staging, held in the SRAM buffer's place
    spl_byte_t stage_q [`SPL_PMAP_BYTES]; // Received map bytes
    logic [`SPL_PMAP_BYTES-1:0] got_q; // Bytes received this frame
    spl_addr_t addr_q; // Lockdown address shift
    logic pmap_live;

    assign pmap_live = (state_q == SPL_ST_PMAP_DATA);

    // Later bytes overwrite earlier ones at the wrapped slot
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            got_q <= '0;
            for (int i = 0; i < `SPL_PMAP_BYTES; i++) begin
                stage_q[i] <= `SPL_PMAP_ERASED;
            end
        end else if (!cs_act) begin
            got_q <= '0;
        end else if (byte_done && pmap_live) begin
            stage_q[cnt_q] <= byte_v;
            got_q[cnt_q] <= 1'b1;
        end
    end

    // Address bytes arrive MSB first; extras are not shifted
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= '0;
        end else if (byte_done && state_q == SPL_ST_LOCK_ADDR &&
                     cnt_q != 2'(`SPL_ADDR_BYTES)) begin
            addr_q <= {addr_q[9:0], byte_v};
        end
    end

    // =========================================================
    // Commit at chip select rise and timed cycle
    logic prog_go, lock_go, cycle_go;
    spl_byte_t pmap_q [`SPL_PMAP_BYTES]; // Protection map
    spl_byte_t lmap_q [`SPL_LMAP_BYTES]; // Lockdown map
    logic [2:0] lock_sec;

    // Only a whole-byte frame commits; a frame with a cut byte is dropped
    assign prog_go = cs_rise & pmap_live & (bit_cnt_q == 3'h0)
        & (got_q != '0);
    assign lock_go = cs_rise & (state_q == SPL_ST_LOCK_ADDR) &
        (cnt_q == 2'(`SPL_ADDR_BYTES)) & (bit_cnt_q == 3'h0);
    assign cycle_go = prog_go | lock_go;
    assign lock_sec = addr_q[`SPL_SECTOR_LSB +: 3];

    spl_prog_timer #(
        .CYCLES(PROGRAM_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(cycle_go),
        .busy(busy)
    );

    // Programming can only clear bits, so an unerased map
    // keeps its cleared bits; prot_en_i plays no part here
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `SPL_PMAP_BYTES; i++) begin
                pmap_q[i] <= `SPL_PMAP_ERASED;
            end
        end else if (prog_go) begin
            for (int i = 0; i < `SPL_PMAP_BYTES; i++) begin
                if (got_q[i]) begin
                    pmap_q[i] <= pmap_q[i] & stage_q[i];
                end
            end
        end
    end

    // Lock bits only ever set: nothing here clears them
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `SPL_LMAP_BYTES; i++) begin
                lmap_q[i] <= `SPL_LMAP_CLEAR;
            end
        end else if (lock_go) begin
            if (lock_sec != 3'h0) begin
                lmap_q[lock_sec] <= `SPL_LOCK_FULL;
            end else if (addr_q < `SPL_SUB0A_LIMIT) begin
                lmap_q[0] <= lmap_q[0] | `SPL_LOCK_0A;
            end else begin
                lmap_q[0] <= lmap_q[0] | `SPL_LOCK_0B;
            end
        end
    end

    // Buffer is working storage for map programming
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            buf_clobber_o <= 1'b0;
        end else begin
            buf_clobber_o <= prog_go;
        end
    end

    assign busy_o = busy;

    // =========================================================
    // Map read shifter, changes on SCK falling edges
    logic [2:0] obit_q; // Bit of the byte being sent
    logic [3:0] obyte_q; // Index of the byte being sent
    logic so_q, so_oe_q;
    spl_byte_t cur_byte;

    // Past the last byte the output is a fixed filler
    always_comb begin
        cur_byte = `SPL_UNDEF_BYTE;
        if (src_q == SPL_SRC_PMAP) begin
            if (obyte_q < 4'(`SPL_PMAP_BYTES)) begin
                cur_byte = pmap_q[obyte_q[1:0]];
            end
        end else if (obyte_q < 4'(`SPL_LMAP_BYTES)) begin
            cur_byte = lmap_q[obyte_q[2:0]];
        end
    end

    // First bit leaves on the falling edge after the last dummy
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            obit_q <= 3'h0;
            obyte_q <= 4'h0;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (!cs_act) begin
            obit_q <= 3'h0;
            obyte_q <= 4'h0;
            so_oe_q <= 1'b0;
        end else if (sck_fall && state_q == SPL_ST_READ_OUT) begin
            so_q <= cur_byte[3'h7 - obit_q];
            so_oe_q <= 1'b1;
            obit_q <= obit_q + 3'h1;
            if (obit_q == 3'h7 && obyte_q != 4'hf) begin
                obyte_q <= obyte_q + 4'h1;
            end
        end
    end

    assign so_o = so_q;
    assign so_oe = so_oe_q;

    // =========================================================
    // Program/erase permission check
    function automatic logic sec_flag(spl_byte_t b, spl_addr_t a);
        logic r;
        r = b[`SPL_S0A_BIT];
        if (a[`SPL_SECTOR_LSB +: 3] == 3'h0) begin
            r = (a < `SPL_SUB0A_LIMIT) ? b[`SPL_S0A_BIT] :
                b[`SPL_S0B_BIT];
        end
        return r;
    endfunction

    logic [2:0] chk_sec;
    logic chk_lock, chk_prot;
    assign chk_sec = chk_addr_i[`SPL_SECTOR_LSB +: 3];
    assign chk_lock = sec_flag(lmap_q[chk_sec], chk_addr_i);
    // Sectors 4..7 have no protection byte in this map
    assign chk_prot = (chk_sec < 3'(`SPL_PMAP_BYTES)) &&
        sec_flag(pmap_q[chk_sec[1:0]], chk_addr_i);

    // Answer one cycle after the request
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            chk_done_o <= 1'b0;
            chk_refuse_o <= 1'b0;
            chk_locked_o <= 1'b0;
        end else begin
            chk_done_o <= chk_valid_i;
            if (chk_valid_i) begin
                chk_locked_o <= chk_lock;
                // Lock wins regardless of map or enable
                chk_refuse_o <= chk_lock |
                    (prot_en_i & chk_prot);
            end
        end
    end

    // =========================================================
    // Map views
    genvar g;
    generate
        for (g = 0; g < `SPL_LMAP_BYTES; g++) begin : g_map
            assign lmap_o[g*8 +: 8] = lmap_q[g];
            if (g < `SPL_PMAP_BYTES) begin : g_p
                assign pmap_o[g*8 +: 8] = pmap_q[g];
            end
        end
    endgenerate
endmodule

// >>> spl_lockdown_checker.sv
`timescale 1ns/1ps
// ============================================================
// Port checker for the map command block
module spl_lockdown_checker #(
    parameter int PROGRAM_CYCLES = 50 // Length of a timed cycle
) (
    input wire logic ref_clk, // System clock
    input wire logic resetn, // Async reset, active low
    input wire logic cs_n_i, // Chip select, active low
    input wire logic sck_i, // Serial clock
    input wire logic si_i, // Serial in
    input wire logic so_o, // Serial out
    input wire logic so_oe, // Serial out enable
    input wire logic prot_en_i, // Global protection enable
    input wire logic chk_valid_i, // Check request
    input wire spl_pkg::spl_addr_t chk_addr_i, // Checked address
    input wire logic chk_done_o, // Check answer strobe
    input wire logic chk_refuse_o, // Refuse flag
    input wire logic chk_locked_o, // Locked flag
    input wire logic busy_o, // Timed cycle running
    input wire logic buf_clobber_o, // Buffer overwritten pulse
    input wire logic [31:0] pmap_o, // Protection map
    input wire logic [63:0] lmap_o // Lockdown map
);
    import spl_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    spl_addr_t a_q; // Address the next answer belongs to
    logic pe_q; // Protection enable seen with it
    int unsigned busy_cnt; // Cycles busy has stood high
    logic [2:0] sec; // Sector of the checked address
    logic lk; // Expected locked flag
    logic pr; // Expected protected flag
    // ============================================================
    // Helper logic
    // Capture the request so the answer can be judged a cycle later
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            a_q <= '0;
            pe_q <= 1'b0;
        end else if (chk_valid_i) begin
            a_q <= chk_addr_i;
            pe_q <= prot_en_i;
        end
    end
    // Count busy cycles; cleared while idle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_o ? busy_cnt + 1 : 0;
        end
    end
    assign sec = a_q[17:15];
    // Sector 0 splits at the 0a/0b boundary: bit 7 or bit 5
    assign lk = (sec == 3'h0) ? lmap_o[a_q < 18'h00800 ? 7 : 5]
                              : lmap_o[{sec, 3'h7}];
    // Sectors 4 to 7 have no protection byte, so never protected
    assign pr = (sec > 3'h3) ? 1'b0
              : (sec == 3'h0) ? pmap_o[a_q < 18'h00800 ? 7 : 5]
              : pmap_o[{sec[1:0], 3'h7}];
    // ============================================================
    // Assertions
    a_check_answer: assert property (chk_valid_i |=> chk_done_o &&
        chk_locked_o == lk && chk_refuse_o == (lk || (pe_q && pr)))
        else $error("check answer wrong");
    a_done_alone: assert property (!chk_valid_i |=> !chk_done_o)
        else $error("check strobe without request");
    a_lock_sticky: assert property (($past(lmap_o) & ~lmap_o) == 64'h0)
        else $error("lockdown bit cleared");
    a_pmap_clear_only: assert property ((~$past(pmap_o) & pmap_o) == 32'h0)
        else $error("protection bit set by programming");
    a_clobber_busy: assert property (buf_clobber_o |-> $rose(busy_o))
        else $error("buffer pulse without cycle start");
    a_clobber_pulse: assert property (buf_clobber_o |=> !buf_clobber_o)
        else $error("buffer pulse too long");
    a_busy_length: assert property ($fell(busy_o) |-> busy_cnt == PROGRAM_CYCLES)
        else $error("timed cycle length wrong");
    a_busy_bounded: assert property (busy_o |-> busy_cnt < PROGRAM_CYCLES)
        else $error("timed cycle overran");
    a_oe_idle: assert property (cs_n_i [*6] |-> !so_oe)
        else $error("output driven while deselected");
    a_maps_framed: assert property (!$stable({pmap_o, lmap_o}) |-> cs_n_i)
        else $error("map changed inside a frame");
endmodule

bind spl_lockdown_cmds spl_lockdown_checker #(
    .PROGRAM_CYCLES(PROGRAM_CYCLES)
) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .cs_n_i(cs_n_i), .sck_i(sck_i),
    .si_i(si_i), .so_o(so_o), .so_oe(so_oe), .prot_en_i(prot_en_i),
    .chk_valid_i(chk_valid_i), .chk_addr_i(chk_addr_i),
    .chk_done_o(chk_done_o), .chk_refuse_o(chk_refuse_o),
    .chk_locked_o(chk_locked_o), .busy_o(busy_o),
    .buf_clobber_o(buf_clobber_o), .pmap_o(pmap_o), .lmap_o(lmap_o)
);

// >>> spl_host_model.sv
`timescale 1ns/1ps
// ============================================================
// Host serial controller, mode 0, 160 ns bit time at 100 MHz
module spl_host_model (
    input wire logic ref_clk, // System clock
    output logic cs_n, // Chip select, active low
    output logic sck, // Serial clock, still low between frames
    output logic si, // Serial data to the device
    input wire logic so, // Serial data from the device
    input wire logic so_oe // Device drives so when high
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Select the device; opcode bytes follow MSB first
    task cs_lo;
        @(posedge ref_clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
    // One byte: data set while low, sampled by both at the rise
    task xbyte(input logic [7:0] tx, output logic [7:0] rx);
        int i;
        for (i = 7; i >= 0; i--) begin
            @(posedge ref_clk);
            si <= tx[i];
            repeat (7) @(posedge ref_clk);
            sck <= 1'b1;
            rx[i] = so_oe ? so : 1'bz;
            repeat (8) @(posedge ref_clk);
            sck <= 1'b0;
        end
    endtask
    // Deselect on a byte boundary; idle data shows no stale bit
    task cs_hi;
        repeat (8) @(posedge ref_clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// >>> spl_lockdown_cmds_tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Bench for the map command block
module spl_lockdown_cmds_tb_top;
    import spl_pkg::*;
    localparam int PCYC = 50; // Short timed cycle keeps the run brief
    logic ref_clk = 1'b0; // System clock
    logic resetn; // Reset, active low
    logic cs_n_i, sck_i, si_i; // Serial pins from the host
    logic so_o, so_oe; // Serial output pin and its enable
    logic prot_en_i, chk_valid_i; // Check side inputs
    spl_addr_t chk_addr_i; // Address to check
    logic chk_done_o, chk_refuse_o, chk_locked_o; // Check answer
    logic busy_o, buf_clobber_o; // Cycle flags
    logic [31:0] pmap_o; // Protection map
    logic [63:0] lmap_o; // Lockdown map
    int err_total, samples_checked, cycles; // Counters
    spl_byte_t rx [0:15]; // Bytes seen during a frame
    spl_byte_t tx [$]; // Bytes to send in a frame
    spl_byte_t ex [$]; // Expected read bytes
    spl_addr_t la [2] = '{18'h01000, 18'h10000}; // Sector 0b, sector 2
    always #5 ref_clk = ~ref_clk;
    spl_lockdown_cmds #(.PROGRAM_CYCLES(PCYC)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .cs_n_i(cs_n_i), .sck_i(sck_i),
        .si_i(si_i), .so_o(so_o), .so_oe(so_oe), .prot_en_i(prot_en_i),
        .chk_valid_i(chk_valid_i), .chk_addr_i(chk_addr_i),
        .chk_done_o(chk_done_o), .chk_refuse_o(chk_refuse_o),
        .chk_locked_o(chk_locked_o), .busy_o(busy_o),
        .buf_clobber_o(buf_clobber_o), .pmap_o(pmap_o), .lmap_o(lmap_o));
    spl_host_model u_host (.ref_clk(ref_clk), .cs_n(cs_n_i), .sck(sck_i),
        .si(si_i), .so(so_o), .so_oe(so_oe));
    // ============================================================
    // Tasks
    task check(input string nm, input logic [63:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Send the queued bytes in one frame
    task frame;
        int i;
        u_host.cs_lo();
        for (i = 0; i < tx.size(); i++) begin
            u_host.xbyte(tx[i], rx[i]);
        end
        u_host.cs_hi();
    endtask
    // Busy must stand after the frame, then drop within a bound
    task wait_idle;
        int n;
        #1;
        check("busy_o", busy_o, 1'b1);
        for (n = 0; n < 200 && busy_o !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        check("busy_o", busy_o, 1'b0);
    endtask
    // Compare read bytes after the opcode and three dummies
    task check_read;
        int i;
        for (i = 0; i < ex.size(); i++) begin
            check("read byte", rx[4 + i], ex[i]);
        end
        check("so_oe", so_oe, 1'b0);
    endtask
    task check_req(input spl_addr_t a, input logic pe, rf, lk);
        @(posedge ref_clk);
        chk_valid_i <= 1'b1;
        chk_addr_i <= a;
        prot_en_i <= pe;
        @(posedge ref_clk);
        chk_valid_i <= 1'b0;
        #1;
        check("chk_done_o", chk_done_o, 1'b1);
        check("chk_refuse_o", chk_refuse_o, rf);
        check("chk_locked_o", chk_locked_o, lk);
    endtask
    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            final_report();
        end
    end
    // ============================================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        prot_en_i = 1'b0;
        chk_valid_i = 1'b0;
        chk_addr_i = '0;
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        check("pmap_o", pmap_o, 32'hffffffff);
        check("lmap_o", lmap_o, 64'h0);
        check("so_oe", so_oe, 1'b0);
        // Program with protection on; fifth byte wraps to sector 0
        prot_en_i <= 1'b1;
        // Only 00 and ff bytes, one rewrite in the run
        tx = '{8'h3d, 8'h2a, 8'h7f, 8'hfc, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00};
        frame();
        check("pmap_o", pmap_o, 32'hff000000);
        wait_idle();
        // Wrong fourth opcode byte: frame ignored, no cycle starts
        tx = '{8'h3d, 8'h2a, 8'h7f, 8'hcf};
        frame();
        #1;
        check("busy_o", busy_o, 1'b0);
        check("pmap_o", pmap_o, 32'hff000000);
        // Read the protection map and one byte past its end
        tx = '{8'h32, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        frame();
        ex = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
        check_read();
        // Lock sector 0b and sector 2 back to back
        foreach (la[k]) begin
            tx = '{8'h3d, 8'h2a, 8'h7f, 8'h30, {6'h00, la[k][17:16]},
                   la[k][15:8], la[k][7:0]};
            frame();
            wait_idle();
        end
        check("lmap_o", lmap_o, 64'h0000000000ff0030);
        // Read the lockdown map back, one byte past its end
        tx = '{8'h35, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
               8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        frame();
        ex = '{8'h30, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        check_read();
        // Locked sectors refuse even with protection off
        check_req(18'h10000, 1'b0, 1'b1, 1'b1);
        check_req(18'h01000, 1'b0, 1'b1, 1'b1);
        check_req(18'h00100, 1'b1, 1'b0, 1'b0);
        check_req(18'h18000, 1'b1, 1'b1, 1'b0);
        check_req(18'h18000, 1'b0, 1'b0, 1'b0);
        check_req(18'h08000, 1'b1, 1'b0, 1'b0);
        check_req(18'h20000, 1'b1, 1'b0, 1'b0);
        final_report();
    end
endmodule
